/* File: hw/mcl_decoder.sv */
// Decoder for the second (low) motion command word of the stepper indexer
module mcl_decoder #(
    parameter int IDLE_PCT_W = 7
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic [15:0]          cmd_hi_word,
    input  wire logic [15:0]          cmd_lo_word,
    input  wire logic [15:0]          cmd_word8,
    input  wire logic [15:0]          cmd_word9,
    input  wire logic                 config_valid,
    input  wire logic                 gpo_configured,
    input  wire logic                 net_home_configured,
    input  wire logic                 home_pin,
    input  wire logic                 index_pulse_pin,
    input  wire logic                 start_indexer_pin,
    input  wire logic                 encoder_target_reached,
    input  wire logic                 flash_done,
    input  wire logic                 flash_ok,
    input  wire logic                 motor_idle,
    input  wire logic [IDLE_PCT_W-1:0] idle_reduction_pct,
    output logic                      driver_current_on_q,
    output logic                      general_output_q,
    output logic                      home_event_q,
    output logic                      reset_errors_q,
    output logic                      clear_fault_q,
    output logic                      blend_start_q,
    output logic                      dwell_start_q,
    output logic                      blend_ccw_q,
    output logic [15:0]               dwell_time_q,
    output logic                      move_start_q,
    output mcl_pkg::mcl_move_kind_s   move_kind_q,
    output logic                      registration_q,
    output logic                      encoder_move_q,
    output logic                      decel_start_q,
    output logic                      gearing_q,
    output logic                      hybrid_q,
    output logic                      save_request_q,
    output logic                      led_green_q,
    output logic                      led_red_q,
    output logic                      locked_q,
    output logic [5:0]                base_current_q,
    output logic [5:0]                motor_current_q
);
    import mcl_pkg::*;
    `include "mcl_params.svh"

    // Refused at elaboration unless 7 or 8 bits wide: a narrower percent field would truncate 100 in the idle scaling
    if (IDLE_PCT_W < 7 || IDLE_PCT_W > 8) begin : g_bad_width
        $error("IDLE_PCT_W must be 7 or 8");
    end

    mcl_low_word_s lo;
    assign lo = mcl_low_word_s'(cmd_lo_word);

    // Pin synchronisers; stage one is read only by stage two
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_prev_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q   <= 3'h0;
            pin_s2_q   <= 3'h0;
            pin_prev_q <= 3'h0;
        end else begin
            pin_s1_q   <= {start_indexer_pin, index_pulse_pin, home_pin};
            pin_s2_q   <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end
    wire [2:0] pin_rise = pin_s2_q & ~pin_prev_q;

    // Command edges from the high word
    logic [15:0] hi_prev_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hi_prev_q <= 16'h0000;
        end else begin
            hi_prev_q <= cmd_hi_word;
        end
    end
    mcl_save_e save_q;
    mcl_save_e save_d;
    wire locked    = (save_q == MCL_LOCKED);
    // Config mode and the post-save lockout block every new command edge; the program move fall is blocked by the lockout only
    wire can_accept = config_valid && !cmd_hi_word[`MCL_HI_CONFIG_MODE] && !locked;
    wire [15:0] hi_rise = cmd_hi_word & ~hi_prev_q & {16{can_accept}};
    wire rise_abs  = hi_rise[`MCL_HI_ABS_MOVE];
    wire rise_rel  = hi_rise[`MCL_HI_REL_MOVE];
    wire rise_jog  = hi_rise[`MCL_HI_JOG_CW] | hi_rise[`MCL_HI_JOG_CCW];
    wire rise_run  = hi_rise[`MCL_HI_RUN_ASSEMBLED];
    wire rise_rst  = hi_rise[`MCL_HI_RESET_ERRORS];
    wire move_cmd  = rise_abs | rise_rel | rise_jog;
    wire prog_fall = hi_prev_q[`MCL_HI_PROGRAM_MOVE] & ~cmd_hi_word[`MCL_HI_PROGRAM_MOVE] & !locked;

    // Indexed move: held while its command bit stays in the output words
    logic           armed_q;
    mcl_move_kind_s armed_kind_q;
    logic           armed_reg_q;
    logic           armed_enc_q;
    wire [2:0] kind_bits = {rise_abs, rise_rel, rise_jog};
    wire [2:0] armed_bits = {armed_kind_q.abs_move, armed_kind_q.rel_move, armed_kind_q.jog_move};
    wire data_still_valid = |(armed_bits & {cmd_hi_word[`MCL_HI_ABS_MOVE], cmd_hi_word[`MCL_HI_REL_MOVE],
                                            cmd_hi_word[`MCL_HI_JOG_CW] | cmd_hi_word[`MCL_HI_JOG_CCW]});
    wire arm_now   = move_cmd && lo.indexed_move_request;
    wire fire_idx  = armed_q && data_still_valid && pin_rise[2] && !locked;
    wire run_now   = move_cmd && !lo.indexed_move_request;
    wire enc_qual  = (rise_abs | rise_rel) && lo.encoder_based_move;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_q      <= 1'b0;
            armed_kind_q <= '0;
            armed_reg_q  <= 1'b0;
            armed_enc_q  <= 1'b0;
        end else if (arm_now) begin
            armed_q      <= 1'b1;
            armed_kind_q <= mcl_move_kind_s'(kind_bits);
            armed_reg_q  <= lo.registration_move_select;
            armed_enc_q  <= enc_qual;
        end else if (run_now || rise_run || !data_still_valid || locked) begin
            armed_q <= 1'b0;
        end
    end

    // Move launch and encoder based deceleration
    logic enc_active_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            move_start_q   <= 1'b0;
            move_kind_q    <= '0;
            registration_q <= 1'b0;
            encoder_move_q <= 1'b0;
            enc_active_q   <= 1'b0;
            decel_start_q  <= 1'b0;
        end else begin
            move_start_q  <= run_now | fire_idx;
            decel_start_q <= enc_active_q && encoder_target_reached;
            if (run_now) begin
                move_kind_q    <= mcl_move_kind_s'(kind_bits);
                registration_q <= rise_jog && lo.registration_move_select;
                encoder_move_q <= enc_qual;
                enc_active_q   <= enc_qual;
            end else if (fire_idx) begin
                move_kind_q    <= armed_kind_q;
                registration_q <= armed_kind_q.jog_move && armed_reg_q;
                encoder_move_q <= armed_enc_q;
                enc_active_q   <= armed_enc_q;
            end else if (encoder_target_reached || rise_run) begin
                enc_active_q <= 1'b0;
            end
        end
    end

    // Assembled move start, sampled at the run edge
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blend_start_q <= 1'b0;
            dwell_start_q <= 1'b0;
            blend_ccw_q   <= 1'b0;
            dwell_time_q  <= 16'h0000;
        end else begin
            blend_start_q <= rise_run && !lo.assembled_move_kind;
            dwell_start_q <= rise_run && lo.assembled_move_kind;
            if (rise_run) begin
                blend_ccw_q  <= lo.blend_direction;
                dwell_time_q <= cmd_word9;
            end
        end
    end

    // Error reset; fault clear relies on the host holding the driver off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reset_errors_q <= 1'b0;
            clear_fault_q  <= 1'b0;
        end else begin
            reset_errors_q <= rise_rst;
            clear_fault_q  <= rise_rst && lo.clear_driver_fault;
        end
    end

    // Level controls; reserved bits 14 and 12 are not decoded
    wire home_gate = !net_home_configured || lo.network_home_proximity;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            driver_current_on_q <= 1'b0;
            general_output_q    <= 1'b0;
            home_event_q        <= 1'b0;
            gearing_q           <= 1'b0;
            hybrid_q            <= 1'b0;
            locked_q            <= 1'b0;
        end else begin
            driver_current_on_q <= lo.driver_current_on && config_valid && !locked;
            general_output_q    <= gpo_configured && lo.general_output_state;
            home_event_q        <= home_gate && (pin_rise[0] || pin_rise[1]);
            gearing_q           <= lo.electronic_gearing_enable && !locked;
            hybrid_q            <= lo.hybrid_control_enable;
            locked_q            <= locked;
        end
    end

    // Save of the assembled move, then lockout until the next reset
    always_comb begin
        save_d = save_q;
        unique case (save_q)
            MCL_RUN: begin
                if (prog_fall && lo.save_assembled_move) begin
                    save_d = MCL_SAVING;
                end
            end
            MCL_SAVING: begin
                if (flash_done) begin
                    save_d = MCL_LOCKED;
                end
            end
            MCL_LOCKED: begin
                save_d = MCL_LOCKED;
            end
            default: begin
                save_d = MCL_LOCKED;
            end
        endcase
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            save_q         <= MCL_RUN;
            save_request_q <= 1'b0;
            led_green_q    <= 1'b0;
            led_red_q      <= 1'b0;
        end else begin
            save_q         <= save_d;
            save_request_q <= (save_q == MCL_RUN) && (save_d == MCL_SAVING);
            if (save_q == MCL_SAVING && flash_done) begin
                led_green_q <= flash_ok;
                led_red_q   <= !flash_ok;
            end
        end
    end

    // On-the-fly base current; older units keep select 00 so this never fires
    wire cur_in_range = (cmd_word8 >= `MCL_CUR_MIN) && (cmd_word8 <= `MCL_CUR_MAX);
    wire cur_take     = ({lo.current_select_hi, lo.current_select_lo} == `MCL_CUR_SEL_ON_FLY)
                        && cur_in_range && !locked;
    wire [5:0]  pct_sat  = (idle_reduction_pct > IDLE_PCT_W'(`MCL_PCT_FULL)) ? 6'h3F : 6'h00;
    wire [6:0]  pct_lim  = (pct_sat != 6'h00) ? `MCL_PCT_FULL : idle_reduction_pct[6:0];
    wire [12:0] cut_prod = 13'(base_current_q) * 13'(pct_lim);
    wire [12:0] cut_amt  = cut_prod / 13'(`MCL_PCT_FULL);
    wire [5:0]  idle_cur = base_current_q - cut_amt[5:0];
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            base_current_q  <= `MCL_CUR_RESET;
            motor_current_q <= `MCL_CUR_RESET;
        end else begin
            if (cur_take) begin
                base_current_q <= cmd_word8[5:0];
            end
            motor_current_q <= motor_idle ? idle_cur : base_current_q;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    drive_needs_config_a: assert property (driver_current_on_q |-> $past(config_valid))
        else $error("driver on without valid configuration");
    gpo_follows_bit_a: assert property ($rose(lo.general_output_state) && gpo_configured |=> general_output_q)
        else $error("general output did not follow bit 13");
    home_gated_a: assert property (home_event_q |-> $past(home_gate))
        else $error("home edge used while proximity bit clear");
    fault_clear_a: assert property (clear_fault_q |-> reset_errors_q && $past(lo.clear_driver_fault))
        else $error("fault clear without reset errors and bit 10");
    assembled_kind_a: assert property (rise_run |=> (blend_start_q != dwell_start_q)
                                       && (dwell_start_q == $past(lo.assembled_move_kind)))
        else $error("assembled move kind wrong");
    index_defer_a: assert property (arm_now |=> !move_start_q)
        else $error("indexed move ran without indexer edge");
    index_rerun_a: assert property (fire_idx |=> move_start_q ##1 !move_start_q)
        else $error("indexed move not rerun");
    gearing_mode_a: assert property (!locked && lo.electronic_gearing_enable |=> gearing_q)
        else $error("gearing mode not entered");
    save_start_a: assert property (prog_fall && lo.save_assembled_move && save_q == MCL_RUN
                                   |=> save_request_q ##1 !save_request_q)
        else $error("save not requested at program end");
    lock_hold_a: assert property (locked |=> !move_start_q && !blend_start_q && !dwell_start_q)
        else $error("command accepted after save");
    current_range_a: assert property (base_current_q != $past(base_current_q)
                                      |-> base_current_q >= 6'h01 && base_current_q <= 6'h28)
        else $error("base current outside 1 to 40");
    current_hold_a: assert property ({lo.current_select_hi, lo.current_select_lo} != 2'h2
                                     |=> $stable(base_current_q))
        else $error("current changed while not selected");
    edge_only_a: assert property (move_start_q && !$past(fire_idx) |-> $past(move_cmd))
        else $error("move started without a rising edge");
endmodule

/* File: pkg/mcl_params.svh */
// Bit positions, ranges and reset values for the low command word decoder
`ifndef MCL_PARAMS_SVH
`define MCL_PARAMS_SVH
`define MCL_HI_ABS_MOVE      0
`define MCL_HI_REL_MOVE      1
`define MCL_HI_JOG_CW        7
`define MCL_HI_JOG_CCW       8
`define MCL_HI_RESET_ERRORS  10
`define MCL_HI_PROGRAM_MOVE  11
`define MCL_HI_RUN_ASSEMBLED 13
`define MCL_HI_CONFIG_MODE   15
`define MCL_CUR_SEL_ON_FLY   2'h2
`define MCL_CUR_MIN          16'h0001
`define MCL_CUR_MAX          16'h0028
`define MCL_CUR_RESET        6'h0A
`define MCL_PCT_FULL         7'h64
`endif

/* File: pkg/mcl_pkg.sv */
// Types shared by the low command word decoder
package mcl_pkg;
    typedef struct packed {
        logic       driver_current_on;
        logic       reserved_14;
        logic       general_output_state;
        logic       reserved_12;
        logic       network_home_proximity;
        logic       clear_driver_fault;
        logic       assembled_move_kind;
        logic       indexed_move_request;
        logic       registration_move_select;
        logic       electronic_gearing_enable;
        logic       save_assembled_move;
        logic       blend_direction;
        logic       hybrid_control_enable;
        logic       encoder_based_move;
        logic       current_select_hi;
        logic       current_select_lo;
    } mcl_low_word_s;

    typedef enum logic [2:0] {
        MCL_RUN    = 3'h1,
        MCL_SAVING = 3'h2,
        MCL_LOCKED = 3'h4
    } mcl_save_e;

    typedef struct packed {
        logic abs_move;
        logic rel_move;
        logic jog_move;
    } mcl_move_kind_s;
endpackage

/* File: dv/mcl_host_model.sv */
// Host model that writes the command words seen by the low word decoder
module mcl_host_model #(
    parameter bit OLD_REV = 1'b0
) (
    input  wire logic        mclk,
    output logic      [15:0] cmd_hi_word,
    output logic      [15:0] cmd_lo_word,
    output logic      [15:0] cmd_word8,
    output logic      [15:0] cmd_word9
);
    timeunit 1ns;
    timeprecision 1ns;
    import mcl_pkg::*;

    initial begin
        cmd_hi_word = 16'h0000;
        cmd_lo_word = 16'h0000;
        cmd_word8   = 16'h0000;
        cmd_word9   = 16'h0000;
    end

    // The host cleans up the word itself, so no scenario can hand the block a malformed low word
    task automatic set_lo(input logic [15:0] v);
        mcl_low_word_s w;
        w = v;
        w.reserved_14 = 1'b0;
        w.reserved_12 = 1'b0;
        if (w.clear_driver_fault) w.driver_current_on = 1'b0;
        if (OLD_REV) {w.current_select_hi, w.current_select_lo} = 2'h0;
        @(posedge mclk);
        cmd_lo_word <= w;
    endtask

    // Callers clear a command bit before raising it again; a bit held high is never re-sent
    task automatic set_hi(input int b, input logic v);
        @(posedge mclk);
        cmd_hi_word[b] <= v;
    endtask

    task automatic set_w(input int n, input logic [15:0] v);
        @(posedge mclk);
        if (n == 8) cmd_word8 <= v;
        else cmd_word9 <= v;
    endtask
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the low command word decoder
`define MCL_CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mcl_pkg::*;

    logic           mclk, rst_n, config_valid, gpo_configured, net_home_configured, home_pin;
    logic           index_pulse_pin, start_indexer_pin, encoder_target_reached, flash_done;
    logic           flash_ok, motor_idle;
    logic [6:0]     idle_reduction_pct;
    logic [15:0]    cmd_hi_word, cmd_lo_word, cmd_word8, cmd_word9, dwell_time_q;
    logic           driver_current_on_q, general_output_q, home_event_q, reset_errors_q;
    logic           clear_fault_q, blend_start_q, dwell_start_q, blend_ccw_q, move_start_q;
    logic           registration_q, encoder_move_q, decel_start_q, gearing_q, hybrid_q;
    logic           save_request_q, led_green_q, led_red_q, locked_q;
    mcl_move_kind_s move_kind_q;
    logic [5:0]     base_current_q, motor_current_q;
    int             err_total = 0;
    int             checked = 0;

    mcl_decoder dut_u (.*);
    mcl_host_model host_u (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic results();
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic quiet(input int sel, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            step(1);
            seen = seen | (sel ? home_event_q : move_start_q);
        end
        `MCL_CHECK(seen, 1'b0)
    endtask

    // Synchronisers make the pin latency approximate, so the wait is bounded rather than fixed
    task automatic wait_hit(input int sel, input int n);
        logic hit;
        hit = 1'b0;
        repeat (n) if (hit !== 1'b1) begin
            step(1);
            hit = sel ? home_event_q : move_start_q;
        end
        `MCL_CHECK(hit, 1'b1)
        if (hit !== 1'b1) results();
    endtask

    task automatic t_levels();
        @(posedge mclk);
        config_valid <= 1'b0;
        host_u.set_lo(16'h8000);
        step(2);
        `MCL_CHECK(driver_current_on_q, 1'b0)
        @(posedge mclk);
        config_valid <= 1'b1;
        step(2);
        `MCL_CHECK(driver_current_on_q, 1'b1)
        host_u.set_lo(16'h6048);
        step(2);
        `MCL_CHECK({general_output_q, gearing_q, hybrid_q}, 3'h7)
        @(posedge mclk);
        gpo_configured <= 1'b0;
        step(2);
        `MCL_CHECK(general_output_q, 1'b0)
        @(posedge mclk);
        gpo_configured <= 1'b1;
        host_u.set_lo(16'h0000);
        step(2);
        `MCL_CHECK({general_output_q, gearing_q, hybrid_q}, 3'h0)
    endtask

    task automatic t_move();
        host_u.set_lo(16'h0004);
        host_u.set_hi(0, 1'b1);
        step(1);
        `MCL_CHECK({move_start_q, move_kind_q, encoder_move_q}, 5'h19)
        step(1);
        `MCL_CHECK(move_start_q, 1'b0)
        @(posedge mclk);
        encoder_target_reached <= 1'b1;
        step(1);
        `MCL_CHECK(decel_start_q, 1'b1)
        @(posedge mclk);
        encoder_target_reached <= 1'b0;
        host_u.set_hi(0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            host_u.set_lo(k ? 16'h0000 : 16'h0080);
            host_u.set_hi(7 + k, 1'b1);
            step(1);
            `MCL_CHECK({move_kind_q, registration_q}, {3'h1, k == 0})
            host_u.set_hi(7 + k, 1'b0);
        end
    endtask

    task automatic t_indexed();
        host_u.set_lo(16'h0100);
        host_u.set_hi(1, 1'b1);
        quiet(0, 4);
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            start_indexer_pin <= 1'b1;
            wait_hit(0, 8);
            @(posedge mclk);
            start_indexer_pin <= 1'b0;
            step(4);
        end
        host_u.set_hi(1, 1'b0);
    endtask

    task automatic t_assembled();
        host_u.set_lo(16'h0010);
        host_u.set_hi(13, 1'b1);
        step(1);
        `MCL_CHECK({blend_start_q, dwell_start_q, blend_ccw_q}, 3'h5)
        host_u.set_hi(13, 1'b0);
        host_u.set_lo(16'h0200);
        host_u.set_w(9, 16'hA5C3);
        host_u.set_hi(13, 1'b1);
        step(1);
        `MCL_CHECK({blend_start_q, dwell_start_q, dwell_time_q}, 18'h1A5C3)
        host_u.set_hi(13, 1'b0);
    endtask

    task automatic t_errors();
        for (int k = 0; k < 2; k++) begin
            host_u.set_lo(k ? 16'h8000 : 16'h8400);
            host_u.set_hi(10, 1'b1);
            step(1);
            `MCL_CHECK({reset_errors_q, clear_fault_q}, {1'b1, k == 0})
            host_u.set_hi(10, 1'b0);
        end
    endtask

    task automatic t_home();
        @(posedge mclk);
        net_home_configured <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            host_u.set_lo(k[0] ? 16'h0800 : 16'h0000);
            @(posedge mclk);
            {index_pulse_pin, home_pin} <= k[1] ? 2'h2 : 2'h1;
            if (k[0]) wait_hit(1, 8);
            else quiet(1, 8);
            @(posedge mclk);
            {index_pulse_pin, home_pin} <= 2'h0;
            step(4);
        end
        // Without network proximity configured the bit must not gate the home input
        host_u.set_lo(16'h0000);
        @(posedge mclk);
        net_home_configured <= 1'b0;
        home_pin <= 1'b1;
        wait_hit(1, 8);
        @(posedge mclk);
        home_pin <= 1'b0;
        step(4);
    endtask

    task automatic t_current();
        host_u.set_lo(16'h0002);
        host_u.set_w(8, 16'h0028);
        step(2);
        `MCL_CHECK({base_current_q, motor_current_q}, {6'h28, 6'h28})
        host_u.set_w(8, 16'h0029);
        step(3);
        `MCL_CHECK(base_current_q, 6'h28)
        host_u.set_w(8, 16'h0000);
        step(3);
        `MCL_CHECK(base_current_q, 6'h28)
        host_u.set_w(8, 16'h0001);
        step(2);
        `MCL_CHECK(base_current_q, 6'h01)
        host_u.set_w(8, 16'h0014);
        step(2);
        `MCL_CHECK(base_current_q, 6'h14)
        for (int s = 0; s < 4; s++) if (s != 2) begin
            host_u.set_lo({14'h0000, 2'(s)});
            host_u.set_w(8, 16'h0005);
            step(3);
            `MCL_CHECK(base_current_q, 6'h14)
        end
        @(posedge mclk);
        motor_idle <= 1'b1;
        idle_reduction_pct <= 7'h32;
        step(3);
        `MCL_CHECK({base_current_q, motor_current_q}, {6'h14, 6'h0A})
        @(posedge mclk);
        idle_reduction_pct <= 7'h7F;
        step(2);
        `MCL_CHECK(motor_current_q, 6'h00)
        @(posedge mclk);
        motor_idle <= 1'b0;
    endtask

    // The lock it provokes lasts until the next reset
    task automatic t_save(input logic ok);
        host_u.set_hi(11, 1'b1);
        host_u.set_lo(16'h0020);
        host_u.set_hi(11, 1'b0);
        step(1);
        `MCL_CHECK(save_request_q, 1'b1)
        @(posedge mclk);
        {flash_done, flash_ok} <= {1'b1, ok};
        @(posedge mclk);
        flash_done <= 1'b0;
        step(1);
        `MCL_CHECK({led_green_q, led_red_q, locked_q}, {ok, !ok, 1'b1})
        host_u.set_lo(16'h8000);
        host_u.set_hi(0, 1'b1);
        quiet(0, 4);
        `MCL_CHECK(driver_current_on_q, 1'b0)
        // Drop the command bit so the next release does not see it as a fresh edge
        host_u.set_hi(0, 1'b0);
    endtask

    // Second release mid-run: only a reset ends the post-save lockout
    task automatic t_reset();
        @(posedge mclk);
        rst_n <= 1'b0;
        step(2);
        @(posedge mclk);
        rst_n <= 1'b1;
        step(2);
        `MCL_CHECK({base_current_q, motor_current_q, locked_q, led_red_q}, {6'h0A, 6'h0A, 2'h0})
    endtask

    initial begin
        rst_n = 1'b0;
        {config_valid, gpo_configured, net_home_configured, home_pin} = 4'h9;
        {index_pulse_pin, start_indexer_pin, encoder_target_reached, flash_done} = 4'h0;
        {flash_ok, motor_idle} = 2'h0;
        idle_reduction_pct = 7'h00;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        home_pin <= 1'b0;
        gpo_configured <= 1'b1;
        step(2);
        `MCL_CHECK({base_current_q, motor_current_q, locked_q}, {6'h0A, 6'h0A, 1'b0})
        t_levels();
        t_move();
        t_indexed();
        t_assembled();
        t_errors();
        t_home();
        t_current();
        t_save(1'b0);
        t_reset();
        t_save(1'b1);
        results();
    end
endmodule
